// ---- rtl/sfc_cfg.svh ----
// Constants of the serial flash identification / OTP / security command block.
// Assumes inclusion by the package and by the design files that need raw numbers.
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH

// Opcodes
`define SFC_OP_WRITE_ENABLE 8'h06
`define SFC_OP_STATUS_WRITE 8'h01
`define SFC_OP_DEEP_PD      8'hb9
`define SFC_OP_PD_RELEASE   8'hab
`define SFC_OP_IDENT_A      8'h90
`define SFC_OP_IDENT_B      8'hdf
`define SFC_OP_IDENT_C      8'hef
`define SFC_OP_OTP_ENTER    8'hb1
`define SFC_OP_OTP_EXIT     8'hc1
`define SFC_OP_SEC_READ     8'h2b
`define SFC_OP_SEC_WRITE    8'h2f
`define SFC_OP_PROT_SELECT  8'h68

// Security register fields
`define SFC_SEC_PROT_SEL 7
`define SFC_SEC_ERASE_FAIL 6
`define SFC_SEC_PROG_FAIL 5
`define SFC_SEC_LOCKDOWN 1
`define SFC_SEC_FACTORY 0

// Frame layout, in bytes including the opcode
`define SFC_DATA_BYTE 3'd4
`define SFC_ADDR_BYTE 3'd3
`define SFC_SEC_HDR 3'd1
`define SFC_IDENT_SWAP_ADDR 8'h01
`define SFC_HOST_ADDR_BYTES 2'd3

// Identity values, arbitrary
`define SFC_MAKER_ID 8'h5a
`define SFC_DEVICE_ID 8'h3c
`define SFC_SIGNATURE_ID 8'h3c

// Timing
`define SFC_CLK_PERIOD_NS 10
`define SFC_RELEASE_RECOVERY_NS 3000
`define SFC_RELEASE_RECOVERY_CYC ((`SFC_RELEASE_RECOVERY_NS + `SFC_CLK_PERIOD_NS - 1) / `SFC_CLK_PERIOD_NS)
`define SFC_REC_W 9
`define SFC_HOST_HALF_CYC 2'd3

`endif

// ---- rtl/sfc_pkg.sv ----
// Types shared by both ends of the serial flash command link.
// Assumes sfc_cfg.svh on the include path.
package sfc_pkg;
`include "sfc_cfg.svh"

  typedef enum logic [1:0] {SFC_H_IDLE, SFC_H_SHIFT, SFC_H_HOLD} sfc_host_st_t;

  typedef struct packed {
    logic [2:0] bitcnt;
    logic [2:0] bytecnt;
    logic       par;
    logic [6:0] shin;
    logic [7:0] op;
    logic [7:0] addr;
    logic [9:0] stat_s1;
    logic [9:0] stat_s2;
  } sfc_dev_link_t;

  typedef struct packed {
    logic       tog;
    logic [7:0] op;
    logic       bound;
    logic [2:0] bytes;
  } sfc_dev_frame_t;

  typedef struct packed {
    logic                  cs_s1;
    logic                  cs_s2;
    logic                  cs_d;
    logic                  tog_s1;
    logic                  tog_s2;
    logic                  seen;
    logic                  strap_done;
    logic                  wel;
    logic                  dpd;
    logic                  otp;
    logic                  prot_sel;
    logic                  lockdown;
    logic                  factory;
    logic                  efail;
    logic                  pfail;
    logic                  blocks_locked;
    logic                  status_wr;
    logic                  standby;
    logic                  otp_wr_ok;
    logic [`SFC_REC_W-1:0] rec;
    logic [9:0]            stat;
  } sfc_dev_sys_t;

  typedef struct packed {
    sfc_host_st_t          st;
    logic                  cs_n;
    logic                  sclk;
    logic                  mosi;
    logic [1:0]            div;
    logic [6:0]            nbits;
    logic [6:0]            rxbits;
    logic [31:0]           txsh;
    logic [7:0]            rxsh;
    logic [2:0]            rxcnt;
    logic [7:0]            rx_byte;
    logic                  rx_valid;
    logic [`SFC_REC_W-1:0] hold;
    logic                  miso_s1;
    logic                  miso_s2;
  } sfc_host_t;

endpackage

// ---- rtl/sfc_link_if.sv ----
// Serial flash link: chip select, serial clock, data in, data out with enable.
// Assumes an idle-high pull on the data-out wire when the device releases it.
`timescale 1ns/10ps
`default_nettype none
interface sfc_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  logic miso_pin;

  // Released wire reads as the pulled-up level
  assign miso_pin = miso_oe_n ? 1'b1 : miso;

  modport dev (input cs_n, input sclk, input mosi, output miso, output miso_oe_n);
  modport host (output cs_n, output sclk, output mosi, input miso_pin);
endinterface
`default_nettype wire

// ---- rtl/sfc_dev.sv ----
// Flash-side command interpreter for release, identification, OTP and security commands.
// Assumes the host stops the serial clock while chip select is high; array engines live outside.
`timescale 1ns/10ps
`default_nettype none
`include "sfc_cfg.svh"
module sfc_dev (
  sfc_link_if.dev          link,
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_busy,
  input  wire logic        i_erase_fail,
  input  wire logic        i_prog_fail,
  input  wire logic        i_unlock,
  input  wire logic        i_nv_factory,
  input  wire logic        i_nv_lockdown,
  input  wire logic        i_nv_prot_sel,
  output logic             o_standby,
  output logic             o_deep_pd,
  output logic             o_otp_mode,
  output logic             o_otp_write_ok,
  output logic             o_prot_sel,
  output logic             o_lockdown,
  output logic             o_blocks_locked,
  output logic             o_status_write,
  output logic [7:0]       o_sec
);
  import sfc_pkg::*;

  sfc_dev_link_t  l;
  sfc_dev_link_t  next_l;
  sfc_dev_frame_t f;
  sfc_dev_frame_t next_f;
  sfc_dev_sys_t   r;
  sfc_dev_sys_t   next_r;
  logic           out_act;
  logic [7:0]     out_byte;
  logic           miso_q;
  logic           miso_oe_n_q;
  logic           frame_rst;

  function automatic logic [7:0] sec_word(input logic ps, input logic ef, input logic pf,
                                          input logic ld, input logic fa);
    sec_word = 8'h00;
    sec_word[`SFC_SEC_PROT_SEL] = ps;
    sec_word[`SFC_SEC_ERASE_FAIL] = ef;
    sec_word[`SFC_SEC_PROG_FAIL] = pf;
    sec_word[`SFC_SEC_LOCKDOWN] = ld;
    sec_word[`SFC_SEC_FACTORY] = fa;
  endfunction

  function automatic logic is_ident(input logic [7:0] op);
    is_ident = (op == `SFC_OP_IDENT_A) || (op == `SFC_OP_IDENT_B) || (op == `SFC_OP_IDENT_C);
  endfunction

  // Link side: cleared while deselected, so a frame always starts at bit 0
  assign frame_rst = i_rst | link.cs_n;

  always_comb begin
    next_l = l;
    next_l.stat_s1 = r.stat;
    next_l.stat_s2 = l.stat_s1;
    next_l.shin = {l.shin[5:0], link.mosi};
    next_l.bitcnt = l.bitcnt + 3'd1;
    if (l.bitcnt == 3'd7) begin
      if (l.bytecnt != `SFC_DATA_BYTE) begin
        next_l.bytecnt = l.bytecnt + 3'd1;
      end else begin
        next_l.par = ~l.par;
      end
      if (l.bytecnt == 3'd0) begin
        next_l.op = {l.shin, link.mosi};
      end
      if (l.bytecnt == `SFC_ADDR_BYTE) begin
        next_l.addr = {l.shin, link.mosi};
      end
    end
    next_f = f;
    next_f.bound = (l.bitcnt == 3'd7);
    next_f.bytes = next_l.bytecnt;
    if (l.bitcnt == 3'd0 && l.bytecnt == 3'd0) begin
      next_f.tog = ~f.tog;
    end
    if (l.bitcnt == 3'd7 && l.bytecnt == 3'd0) begin
      next_f.op = {l.shin, link.mosi};
    end
  end

  always_ff @(posedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // Frame summary survives deselect so the system side can act on it
  always_ff @(posedge link.sclk or posedge i_rst) begin
    if (i_rst) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  // Read data selection; status word is quasi-static during a frame
  always_comb begin
    out_act = 1'b0;
    out_byte = 8'h00;
    if (l.op == `SFC_OP_PD_RELEASE) begin
      out_act = (l.bytecnt == `SFC_DATA_BYTE) && !l.stat_s2[9];
      out_byte = `SFC_SIGNATURE_ID;
    end else if (is_ident(l.op)) begin
      out_act = (l.bytecnt == `SFC_DATA_BYTE) && !l.stat_s2[8];
      out_byte = (((l.addr == `SFC_IDENT_SWAP_ADDR) ^ l.par) ? `SFC_DEVICE_ID : `SFC_MAKER_ID);
    end else if (l.op == `SFC_OP_SEC_READ) begin
      out_act = (l.bytecnt >= `SFC_SEC_HDR) && !l.stat_s2[8];
      out_byte = l.stat_s2[7:0];
    end
  end

  // Output changes on the falling edge, most significant bit first
  always_ff @(negedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      miso_q <= 1'b0;
      miso_oe_n_q <= 1'b1;
    end else begin
      miso_q <= out_byte[~l.bitcnt];
      miso_oe_n_q <= ~out_act;
    end
  end

  assign link.miso = miso_q;
  assign link.miso_oe_n = miso_oe_n_q;

  // System side: executes the frame once chip select is seen high
  always_comb begin
    next_r = r;
    next_r.cs_s1 = link.cs_n;
    next_r.cs_s2 = r.cs_s1;
    next_r.cs_d = r.cs_s2;
    next_r.tog_s1 = f.tog;
    next_r.tog_s2 = r.tog_s1;
    next_r.status_wr = 1'b0;
    if (!r.strap_done) begin
      next_r.strap_done = 1'b1;
      next_r.factory = i_nv_factory;
      next_r.lockdown = i_nv_lockdown;
      next_r.prot_sel = i_nv_prot_sel;
      next_r.blocks_locked = i_nv_prot_sel;
    end
    if (i_unlock) begin
      next_r.blocks_locked = 1'b0;
    end
    if (r.rec != '0) begin
      next_r.rec = r.rec - `SFC_REC_W'(1);
    end
    if (r.cs_s2 && !r.cs_d && (r.tog_s2 != r.seen)) begin
      next_r.seen = r.tog_s2;
      if (f.bound) begin
        if (r.dpd) begin
          if (f.op == `SFC_OP_PD_RELEASE && !i_busy) begin
            next_r.dpd = 1'b0;
            next_r.rec = `SFC_REC_W'(`SFC_RELEASE_RECOVERY_CYC);
          end
        end else if (!i_busy) begin
          unique case (f.op)
            `SFC_OP_WRITE_ENABLE: next_r.wel = 1'b1;
            `SFC_OP_DEEP_PD:      next_r.dpd = 1'b1;
            `SFC_OP_OTP_ENTER:    next_r.otp = 1'b1;
            `SFC_OP_OTP_EXIT:     next_r.otp = r.otp && (f.bytes != 3'd1);
            `SFC_OP_SEC_WRITE: begin
              if (r.wel && !r.otp) begin
                next_r.lockdown = 1'b1;
                next_r.wel = 1'b0;
              end
            end
            `SFC_OP_PROT_SELECT: begin
              if (r.wel && !r.otp) begin
                next_r.prot_sel = 1'b1;
                next_r.wel = 1'b0;
              end
            end
            `SFC_OP_STATUS_WRITE: begin
              if (r.wel && !r.otp) begin
                next_r.status_wr = 1'b1;
                next_r.wel = 1'b0;
              end
            end
            default: next_r.wel = r.wel;
          endcase
        end
      end
    end
    // Fail flags are sticky; only reset clears them
    if (i_erase_fail) begin
      next_r.efail = 1'b1;
    end
    if (i_prog_fail) begin
      next_r.pfail = 1'b1;
    end
    next_r.standby = !next_r.dpd && (next_r.rec == '0);
    next_r.otp_wr_ok = next_r.otp && !next_r.lockdown;
    next_r.stat = {i_busy, next_r.dpd,
                   sec_word(next_r.prot_sel, next_r.efail, next_r.pfail, next_r.lockdown, next_r.factory)};
  end

  // Only reset clears the protection select bit once set
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_standby = r.standby;
  assign o_deep_pd = r.dpd;
  assign o_otp_mode = r.otp;
  assign o_otp_write_ok = r.otp_wr_ok;
  assign o_prot_sel = r.prot_sel;
  assign o_lockdown = r.lockdown;
  assign o_blocks_locked = r.blocks_locked;
  assign o_status_write = r.status_wr;
  assign o_sec = r.stat[7:0];
endmodule
`default_nettype wire

// ---- rtl/sfc_host.sv ----
// Host-side frame engine: drives chip select, a divided serial clock and data, collects read bytes.
// Assumes the user waits for o_busy low before starting and issues write-enable frames itself.
`timescale 1ns/10ps
`default_nettype none
`include "sfc_cfg.svh"
module sfc_host (
  sfc_link_if.host         link,
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_start,
  input  wire logic [7:0]  i_opcode,
  input  wire logic [1:0]  i_tx_len,
  input  wire logic [23:0] i_tx_data,
  input  wire logic [3:0]  i_rx_len,
  output logic             o_busy,
  output logic             o_rx_valid,
  output logic [7:0]       o_rx_byte
);
  import sfc_pkg::*;

  sfc_host_t h;
  sfc_host_t next_h;
  logic [1:0] txl;
  logic [3:0] rxl;

  always_comb begin
    next_h = h;
    next_h.miso_s1 = link.miso_pin;
    next_h.miso_s2 = h.miso_s1;
    next_h.rx_valid = 1'b0;
    txl = i_tx_len;
    rxl = i_rx_len;
    if (i_opcode == `SFC_OP_IDENT_A || i_opcode == `SFC_OP_IDENT_B || i_opcode == `SFC_OP_IDENT_C) begin
      txl = `SFC_HOST_ADDR_BYTES;
    end
    if (i_opcode == `SFC_OP_PD_RELEASE && i_rx_len != 4'd0 && rxl == 4'd0) begin
      rxl = 4'd1;
    end
    if (i_opcode == `SFC_OP_PD_RELEASE && i_rx_len != 4'd0) begin
      txl = `SFC_HOST_ADDR_BYTES;
    end
    unique case (h.st)
      SFC_H_IDLE: begin
        if (i_start) begin
          next_h.st = SFC_H_SHIFT;
          next_h.cs_n = 1'b0;
          next_h.sclk = 1'b0;
          next_h.div = 2'd0;
          next_h.txsh = {i_opcode, i_tx_data};
          next_h.mosi = i_opcode[7];
          // Header byte count needs three bits; more than fifteen header and read bytes together overflow the count
          next_h.nbits = {1'b0, {1'b0, txl} + 3'd1, 3'b000} + {rxl, 3'b000};
          next_h.rxbits = {rxl, 3'b000};
          next_h.rxcnt = 3'd0;
        end
      end
      SFC_H_SHIFT: begin
        next_h.div = h.div + 2'd1;
        if (h.div == `SFC_HOST_HALF_CYC) begin
          next_h.sclk = ~h.sclk;
          if (!h.sclk) begin
            // Rising edge: device samples data; read data settled since the falling edge
            next_h.nbits = h.nbits - 7'd1;
            if (h.nbits <= h.rxbits) begin
              next_h.rxsh = {h.rxsh[6:0], h.miso_s2};
              next_h.rxcnt = h.rxcnt + 3'd1;
              if (h.rxcnt == 3'd7) begin
                next_h.rx_byte = {h.rxsh[6:0], h.miso_s2};
                next_h.rx_valid = 1'b1;
              end
            end
          end else if (h.nbits == 7'd0) begin
            // Frame always ends on a byte boundary
            next_h.st = SFC_H_HOLD;
            next_h.cs_n = 1'b1;
            next_h.hold = `SFC_REC_W'(`SFC_RELEASE_RECOVERY_CYC);
          end else begin
            next_h.txsh = {h.txsh[30:0], 1'b0};
            next_h.mosi = h.txsh[30];
          end
        end
      end
      SFC_H_HOLD: begin
        // Deselect time covers the worst-case release recovery
        next_h.hold = h.hold - `SFC_REC_W'(1);
        if (h.hold == `SFC_REC_W'(1)) begin
          next_h.st = SFC_H_IDLE;
        end
      end
      default: next_h.st = SFC_H_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      h <= '{st: SFC_H_IDLE, cs_n: 1'b1, default: '0};
    end else begin
      h <= next_h;
    end
  end

  assign link.cs_n = h.cs_n;
  assign link.sclk = h.sclk;
  assign link.mosi = h.mosi;
  assign o_busy = (h.st != SFC_H_IDLE);
  assign o_rx_valid = h.rx_valid;
  assign o_rx_byte = h.rx_byte;
endmodule
`default_nettype wire

// ---- test/sfc_link_props.sv ----
// Link assertions for the serial flash command link between host and device ends.
// Assumes the link signals plus the system clock and reset that both ends share.
`timescale 1ns/10ps
`default_nettype none
module sfc_link_props (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_oe_n,
  input wire logic miso_pin
);
  logic [8:0] gap;
  logic [8:0] next_gap;

  // Saturating count of deselected cycles; starts full so the first frame is legal
  always_comb begin
    next_gap = gap;
    if (!cs_n)
      next_gap = 9'h000;
    else if (gap != 9'h1ff)
      next_gap = gap + 9'h001;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst)
      gap <= 9'h1ff;
    else
      gap <= next_gap;
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence s_high_phase;
    sclk [*4];
  endsequence

  sequence s_low_lead;
    !sclk [*3];
  endsequence

  AST_DESEL_OE_OFF: assert property (cs_n |-> miso_oe_n)
    else $error("data out driven while deselected");
  AST_SCLK_STILL: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("serial clock moves between frames");
  AST_MISO_FALL_ONLY: assert property (!cs_n && $changed(miso_pin) |-> $fell(sclk))
    else $error("data out changed off a falling clock edge");
  AST_OE_ON_FALL: assert property ($fell(miso_oe_n) |-> $fell(sclk))
    else $error("output enabled off a falling clock edge");
  AST_MOSI_HELD: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("data in changed while clock high");
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> s_high_phase ##1 !sclk)
    else $error("clock high phase not four cycles");
  AST_FRAME_LEAD: assert property ($fell(cs_n) |-> s_low_lead)
    else $error("clock rose too soon after select");
  AST_CS_RECOVERY: assert property ($fell(cs_n) |-> gap >= 9'd300)
    else $error("select high time below recovery");
  AST_RELEASED_HIGH: assert property ($rose(cs_n) |-> miso_pin)
    else $error("released data line not pulled high");
endmodule
`default_nettype wire

// ---- test/tb_serial_flash_id_otp_security_cmds.sv ----
// Testbench joining host and device ends through the link, driving both user sides.
// Assumes the package, link interface, both ends and sfc_link_props compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_serial_flash_id_otp_security_cmds;
  import sfc_pkg::*;
`include "sfc_cfg.svh"
  logic       i_clk_sys;
  logic       i_rst = 1'b1;
  logic       busy_in = 1'b0;
  logic       efail = 1'b0;
  logic       pfail = 1'b0;
  logic       unlock = 1'b0;
  logic       nv_fac = 1'b1;
  logic       nv_ps = 1'b0;
  logic       nv_ld = 1'b0;
  logic       start = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [1:0] tx_len = 2'h0;
  logic [23:0] tx_data = 24'h000000;
  logic [3:0] rx_len = 4'h0;
  logic       standby, deep_pd, otp_mode, otp_wr_ok, prot_sel, lockdown, blk_locked, status_wr, h_busy, rx_valid;
  logic [7:0] sec, rx_byte;
  logic [7:0] rx[$];
  int         sw_cnt = 0;
  int         num_errors = 0;
  int         checks = 0;
  int         cyc = 0;

  sfc_link_if link();
  sfc_dev sfc_dev_i (.link(link), .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_busy(busy_in),
    .i_erase_fail(efail), .i_prog_fail(pfail), .i_unlock(unlock), .i_nv_factory(nv_fac),
    .i_nv_lockdown(nv_ld), .i_nv_prot_sel(nv_ps), .o_standby(standby), .o_deep_pd(deep_pd),
    .o_otp_mode(otp_mode), .o_otp_write_ok(otp_wr_ok), .o_prot_sel(prot_sel), .o_lockdown(lockdown),
    .o_blocks_locked(blk_locked), .o_status_write(status_wr), .o_sec(sec));
  sfc_host sfc_host_i (.link(link), .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_start(start),
    .i_opcode(opcode), .i_tx_len(tx_len), .i_tx_data(tx_data), .i_rx_len(rx_len),
    .o_busy(h_busy), .o_rx_valid(rx_valid), .o_rx_byte(rx_byte));
  sfc_link_props sfc_link_props_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .cs_n(link.cs_n),
    .sclk(link.sclk), .mosi(link.mosi), .miso_oe_n(link.miso_oe_n), .miso_pin(link.miso_pin));

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // Status-write pulse lasts one cycle, so count it for later judgement
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (status_wr === 1'b1)
      sw_cnt <= sw_cnt + 1;
    if (cyc == 60000) begin
      num_errors = num_errors + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    if (num_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  // Starts a frame and returns just after chip select rises, bytes collected
  task automatic go(input logic [7:0] op, input logic [1:0] txl, input logic [23:0] txd, input logic [3:0] rxl);
    int n;
    rx.delete();
    @(negedge i_clk_sys);
    start = 1'b1;
    opcode = op;
    tx_len = txl;
    tx_data = txd;
    rx_len = rxl;
    @(negedge i_clk_sys);
    start = 1'b0;
    n = 0;
    while (link.cs_n !== 1'b0 && n < 20) begin
      @(negedge i_clk_sys);
      n++;
    end
    while (link.cs_n !== 1'b1 && n < 2000) begin
      if (rx_valid === 1'b1)
        rx.push_back(rx_byte);
      @(negedge i_clk_sys);
      n++;
    end
    cmp1(link.cs_n, 1'b1);
  endtask

  task automatic fin();
    int n;
    n = 0;
    while (h_busy !== 1'b0 && n < 1000) begin
      if (rx_valid === 1'b1)
        rx.push_back(rx_byte);
      @(negedge i_clk_sys);
      n++;
    end
    cmp1(h_busy, 1'b0);
  endtask

  task automatic run(input logic [7:0] op, input logic [1:0] txl, input logic [23:0] txd, input logic [3:0] rxl);
    go(op, txl, txd, rxl);
    fin();
  endtask

  task automatic cmd(input logic [7:0] op);
    run(op, 2'h0, 24'h000000, 4'h0);
  endtask

  task automatic t_reset();
    cmp8(sec, 8'h01);
    cmp1(standby, 1'b1);
    run(`SFC_OP_SEC_READ, 2'h0, 24'h000000, 4'h2);
    cmp8(rx[0], 8'h01);
    cmp8(rx[1], 8'h01);
  endtask

  task automatic t_ident();
    logic [7:0] ops[3];
    logic [7:0] first;
    logic [7:0] other;
    ops = '{`SFC_OP_IDENT_A, `SFC_OP_IDENT_B, `SFC_OP_IDENT_C};
    for (int i = 0; i < 3; i++) begin
      run(ops[i], 2'h3, {16'h0000, 8'(i)}, 4'h3);
      first = (i == 1) ? `SFC_DEVICE_ID : `SFC_MAKER_ID;
      other = (i == 1) ? `SFC_MAKER_ID : `SFC_DEVICE_ID;
      cmp8(rx[0], first);
      cmp8(rx[1], other);
      cmp8(rx[2], first);
    end
  endtask

  task automatic t_fail();
    @(negedge i_clk_sys);
    efail = 1'b1;
    pfail = 1'b1;
    @(negedge i_clk_sys);
    efail = 1'b0;
    pfail = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    cmp8(sec, 8'h61);
  endtask

  task automatic t_otp();
    cmd(`SFC_OP_OTP_ENTER);
    cmp1(otp_mode, 1'b1);
    cmp1(otp_wr_ok, 1'b1);
    cmd(`SFC_OP_WRITE_ENABLE);
    cmd(`SFC_OP_PROT_SELECT);
    cmp1(prot_sel, 1'b0);
    cmd(`SFC_OP_WRITE_ENABLE);
    cmd(`SFC_OP_STATUS_WRITE);
    cmp8(8'(sw_cnt), 8'h00);
    cmd(`SFC_OP_OTP_EXIT);
    cmp1(otp_mode, 1'b0);
    // A refused write may leave the latch set; consume it so later scenarios start clean
    cmd(`SFC_OP_WRITE_ENABLE);
    cmd(`SFC_OP_STATUS_WRITE);
    cmp8(8'(sw_cnt), 8'h01);
  endtask

  task automatic t_lock();
    cmd(`SFC_OP_SEC_WRITE);
    cmp1(lockdown, 1'b0);
    cmd(`SFC_OP_WRITE_ENABLE);
    cmd(`SFC_OP_SEC_WRITE);
    cmp1(lockdown, 1'b1);
    cmp8(sec, 8'h63);
    cmd(`SFC_OP_OTP_ENTER);
    cmp1(otp_wr_ok, 1'b0);
    cmd(`SFC_OP_OTP_EXIT);
    cmd(`SFC_OP_WRITE_ENABLE);
    cmd(`SFC_OP_STATUS_WRITE);
    cmp8(8'(sw_cnt), 8'h02);
  endtask

  task automatic t_prot();
    cmd(`SFC_OP_WRITE_ENABLE);
    cmd(`SFC_OP_PROT_SELECT);
    cmp1(prot_sel, 1'b1);
    cmd(`SFC_OP_WRITE_ENABLE);
    cmd(`SFC_OP_SEC_WRITE);
    cmp8(sec, 8'he3);
  endtask

  task automatic t_pd();
    int n;
    cmd(`SFC_OP_DEEP_PD);
    cmp1(standby, 1'b0);
    run(`SFC_OP_SEC_READ, 2'h0, 24'h000000, 4'h1);
    cmp8(rx[0], 8'hff);
    cmd(`SFC_OP_OTP_ENTER);
    cmp1(otp_mode, 1'b0);
    busy_in = 1'b1;
    cmd(`SFC_OP_PD_RELEASE);
    cmp1(deep_pd, 1'b1);
    busy_in = 1'b0;
    go(`SFC_OP_PD_RELEASE, 2'h0, 24'h000000, 4'h2);
    repeat (10) @(negedge i_clk_sys);
    cmp1(standby, 1'b0);
    cmp1(deep_pd, 1'b0);
    n = 10;
    while (standby !== 1'b1 && n < 600) begin
      @(negedge i_clk_sys);
      n++;
    end
    cmp1(n >= 295 && n <= 315, 1'b1);
    fin();
    cmp8(rx[0], `SFC_SIGNATURE_ID);
    cmp8(rx[1], `SFC_SIGNATURE_ID);
    go(`SFC_OP_PD_RELEASE, 2'h0, 24'h000000, 4'h0);
    repeat (6) @(negedge i_clk_sys);
    cmp1(standby, 1'b1);
    cmp8(sec, 8'he3);
    fin();
  endtask

  // A second power-on with the scheme and lockdown straps kept; volatile flags must be gone
  task automatic t_power_on();
    nv_ps = 1'b1;
    nv_ld = 1'b1;
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    i_rst = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    cmp1(blk_locked, 1'b1);
    cmp8(sec, 8'h83);
    cmp1(lockdown, 1'b1);
    unlock = 1'b1;
    @(negedge i_clk_sys);
    unlock = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    cmp1(blk_locked, 1'b0);
  endtask

  initial begin
    repeat (2) @(negedge i_clk_sys);
    i_rst = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    t_reset();
    t_ident();
    t_fail();
    t_otp();
    t_lock();
    t_prot();
    t_pd();
    t_power_on();
    stop_test();
  end
endmodule
`default_nettype wire
